/* File: rtl/e1_tx_device.sv */
// e1 transmit path: input formats, encoder, shaper, driver control
// How it works
// - two-bit field picks one of three formats
// - single rail: data plus clock, then encoded
// - dual rail nrz: encoded rails plus clock
// - rz rails: clock recovered from rails only
// - polarity bit inverts data, edge bit picks edge
// - clock loss status after 65 idle ticks
// - loss flag on rise or any change
// - encoder used only in single rail mode
// - ami or hdb3 chosen by code bit
// - software picks preset template 0000 to 0111
// - trim 100001 nominal, 3% per step
// - template msb set selects user waveform
// - waveform spans 1.25 ui in 20 phases
// - samples are seven-bit signed magnitude
// - eight preset templates held in rom
// - write: load sample, then index, dir 0, done
// - read: index, dir 1, done, then read sample
// - overlap overflow sets maskable flag
// - pin or bit low floats the driver
// - over-current limits or floats the driver
// - over-current status, edge flag, maskable
// - clock loss floats driver in clocked modes
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module e1_tx_device (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic nrst_i, // sync reset, active low
  e1_tx_link_if.device link, // link from the framer
  input wire logic [5:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic global_oe_i, // global driver enable pin
  input wire logic tx_overcurrent_i, // over-current detector
  output logic line_out_positive_o, // positive pulse active
  output logic line_out_negative_o, // negative pulse active
  output logic line_oe_n_o, // low while the driver drives
  output logic current_limit_o, // driver current limiting
  output logic [6:0] shaper_level_o, // signed magnitude level
  output logic irq_n_o // interrupt, active low
);
  typedef struct packed {
    logic clk_s1, clk_s2, clk_s3;
    logic [2:0] d_s1, d_s2;
    logic oc_s1, oc_s2, oc_prev;
    logic oe_s1, oe_s2;
    logic rz_prev;
    logic [5:0] tick_cnt;
    logic [6:0] loss_cnt;
    logic loss;
    logic [6:0] ui_cnt;
    logic [1:0] ph_cnt;
    logic [4:0] ph;
    logic [1:0] cur, prev;
    logic [3:0][1:0] pipe;
    logic [1:0] zcnt;
    logic par, last_pol;
    logic [4:0] fmt;
    logic [3:0] tsel;
    logic [5:0] trim;
    logic [6:0] acc, sdata;
    logic [7:0] line, flags, edgem, mask;
    logic [19:0][6:0] ram;
    logic wreq;
    logic [31:0] rdata;
    logic lp, ln, oe_n, ilim, irq_n;
    logic [6:0] level;
  } dev_state_type;

  dev_state_type s, n;
  logic [2:0] din;
  logic rise, fall, clk_edge, tick, strobe, loss_now, rz, loss_ev, oc_ev;
  logic [1:0] sym, kind;
  logic sym_pos;
  logic signed [8:0] va, vb, sum;
  logic [7:0] wd;

  // peak of preset shape sel, one step lower per index
  function automatic logic [5:0] preset_peak_sel(input logic [2:0] sel);
    preset_peak_sel = e1_tx_pkg::PRESET_PEAK - {3'h0, sel};
  endfunction

  // preset rom: eight shapes, pulse then small undershoot
  function automatic logic [6:0] preset_sample(input logic [2:0] sel,
                                               input logic [4:0] ph);
    if (ph < 5'h08) begin
      preset_sample = {1'b0, preset_peak_sel(sel)};
    end else if (ph < 5'h0a) begin
      preset_sample = e1_tx_pkg::PRESET_UNDER;
    end else begin
      preset_sample = 7'h00;
    end
  endfunction

  // phase sample, preset or user table, trimmed, signed
  function automatic logic signed [8:0] shaped(input logic [3:0] tsel,
      input logic [19:0][6:0] ram, input logic [5:0] trim,
      input logic [4:0] ph, input logic [1:0] symb);
    logic [6:0] raw;
    logic [16:0] prod;
    logic [8:0] mag;
    raw = tsel[e1_tx_pkg::TSEL_USER_BIT] ? ram[ph] :
          preset_sample(tsel[2:0], ph);
    // 31/1024 stands in for 1/33 so nominal trim gives unity
    prod = 17'(raw[5:0]) * 17'(trim) * 17'd31;
    mag = {2'b00, prod[16:10]};
    if (symb == 2'b00 || ph > 5'(e1_tx_pkg::PHASE_LAST)) begin
      shaped = 9'sh000;
    end else if (raw[6] ^ symb[1]) begin
      shaped = -$signed(mag);
    end else begin
      shaped = $signed(mag);
    end
  endfunction

  always_comb begin
    n = s;
    // two-flop synchronisers on every foreign input
    n.clk_s1 = link.tx_system_clock;
    n.clk_s2 = s.clk_s1;
    n.clk_s3 = s.clk_s2;
    n.d_s1 = {link.tx_negative_rail, link.tx_positive_rail,
              link.tx_single_rail_data};
    n.d_s2 = s.d_s1;
    n.oc_s1 = tx_overcurrent_i;
    n.oc_s2 = s.oc_s1;
    n.oe_s1 = global_oe_i;
    n.oe_s2 = s.oe_s1;
    din = s.d_s2 ^ {3{s.fmt[e1_tx_pkg::POL_BIT]}};
    rise = s.clk_s2 & ~s.clk_s3;
    fall = ~s.clk_s2 & s.clk_s3;
    clk_edge = s.fmt[e1_tx_pkg::CLKEDGE_BIT] ? fall : rise;
    // e1 tick from the local clock
    tick = (s.tick_cnt == 6'(e1_tx_pkg::E1_TICK_CYCLES - 1));
    n.tick_cnt = tick ? 6'h00 : s.tick_cnt + 6'h01;
    // clock loss watchdog, counts saturate
    if (rise | fall) begin
      n.loss_cnt = 7'h00;
    end else if (tick && s.loss_cnt <= 7'(e1_tx_pkg::LOSS_LIMIT)) begin
      n.loss_cnt = s.loss_cnt + 7'h01;
    end
    loss_now = (s.fmt[1:0] != e1_tx_pkg::MODE_DUAL_RZ) &&
               (s.loss_cnt > 7'(e1_tx_pkg::LOSS_LIMIT));
    n.loss = loss_now;
    // encoder output side: polarity of the oldest symbol
    kind = s.pipe[3];
    sym_pos = (kind == e1_tx_pkg::KIND_VIOL) ? s.last_pol : ~s.last_pol;
    // format select
    rz = din[1] | din[2];
    n.rz_prev = rz;
    n.ui_cnt = (s.ui_cnt == 7'h7f) ? s.ui_cnt : s.ui_cnt + 7'h01;
    strobe = 1'b0;
    sym = 2'b00;
    case (s.fmt[1:0])
      e1_tx_pkg::MODE_SINGLE: begin
        strobe = clk_edge;
        sym = (kind == e1_tx_pkg::KIND_ZERO) ? 2'b00 :
              (sym_pos ? 2'b01 : 2'b10);
      end
      e1_tx_pkg::MODE_DUAL_NRZ: begin
        strobe = clk_edge;
        sym = din[2:1];
      end
      default: begin
        // recovered clock: mark edges, free run through zeros
        if (rz && !s.rz_prev &&
            s.ui_cnt >= 7'(e1_tx_pkg::RZ_MIN_CYCLES)) begin
          strobe = 1'b1;
          sym = din[2:1];
        end else if (s.ui_cnt == 7'(e1_tx_pkg::RZ_LATE_CYCLES)) begin
          strobe = 1'b1;
        end
      end
    endcase
    if (strobe) begin
      n.ui_cnt = 7'h00;
    end
    // ami / hdb3 encoder, four-symbol delay for substitution
    if (strobe && s.fmt[1:0] == e1_tx_pkg::MODE_SINGLE) begin
      if (kind != e1_tx_pkg::KIND_ZERO) begin
        n.last_pol = sym_pos;
      end
      n.pipe = {s.pipe[2:0], din[0] ? e1_tx_pkg::KIND_MARK :
                                      e1_tx_pkg::KIND_ZERO};
      n.zcnt = din[0] ? 2'h0 : ((s.zcnt == 2'h3) ? 2'h3 : s.zcnt + 2'h1);
      if (din[0]) begin
        n.par = ~s.par;
      end else if (s.fmt[e1_tx_pkg::CODE_BIT] && s.zcnt == 2'h3) begin
        // fourth zero: 000v after odd pulses, b00v after even
        n.pipe[0] = e1_tx_pkg::KIND_VIOL;
        if (!s.par) begin
          n.pipe[3] = e1_tx_pkg::KIND_BAL;
        end
        n.par = 1'b0;
        n.zcnt = 2'h0;
      end
    end
    // shaper: 20 phases, tail of previous pulse overlaps
    if (strobe) begin
      n.prev = s.cur;
      n.cur = sym;
      n.ph = 5'h00;
      n.ph_cnt = 2'h0;
    end else if (s.ph_cnt == 2'(e1_tx_pkg::PHASE_CYCLES - 1)) begin
      n.ph_cnt = 2'h0;
      if (s.ph < 5'(e1_tx_pkg::PHASE_LAST)) begin
        n.ph = s.ph + 5'h01;
      end
    end else begin
      n.ph_cnt = s.ph_cnt + 2'h1;
    end
    va = shaped(s.tsel, s.ram, s.trim, s.ph, s.cur);
    vb = (s.ph < 5'(e1_tx_pkg::TAIL_PHASES)) ?
         shaped(s.tsel, s.ram, s.trim, s.ph + 5'(e1_tx_pkg::TAIL_OFFSET),
                s.prev) : 9'sh000;
    sum = va + vb;
    n.lp = sum > 9'sh000;
    n.ln = sum < 9'sh000;
    if (sum > 9'sh03f || sum < -9'sh03f) begin
      n.level = {sum[8], 6'h3f}; // saturate at full scale
    end else begin
      n.level = {sum[8], sum[8] ? 6'(-sum) : 6'(sum)};
    end
    // driver float and current limit
    n.oe_n = ~s.oe_s2 | ~s.line[e1_tx_pkg::OE_BIT] | loss_now |
             (s.oc_s2 & s.line[e1_tx_pkg::FLOAT_BIT]);
    n.ilim = s.oc_s2 & ~s.line[e1_tx_pkg::FLOAT_BIT];
    n.oc_prev = s.oc_s2; // over-current status
    // event detect, rising only or any change
    loss_ev = s.edgem[e1_tx_pkg::LOSS_BIT] ? (loss_now != s.loss) :
              (loss_now & ~s.loss);
    oc_ev = s.edgem[e1_tx_pkg::OC_BIT] ? (s.oc_s2 != s.oc_prev) :
            (s.oc_s2 & ~s.oc_prev);
    // waveform memory access, done clears itself
    if (s.acc[e1_tx_pkg::DONE_BIT]) begin
      if (s.acc[4:0] <= 5'(e1_tx_pkg::PHASE_LAST)) begin
        if (s.acc[e1_tx_pkg::DIR_BIT]) begin
          n.sdata = s.ram[s.acc[4:0]];
        end else begin
          n.ram[s.acc[4:0]] = s.sdata;
        end
      end
      n.acc[e1_tx_pkg::DONE_BIT] = 1'b0;
    end
    // avalon slave: one wait cycle, then write or read data
    wd = avs_writedata_i[7:0];
    if ((avs_read_i | avs_write_i) && s.wreq) begin
      n.wreq = 1'b0;
      n.rdata = 32'h0000_0000;
      case (avs_address_i & 6'h3c)
        e1_tx_pkg::ADDR_FORMAT: n.rdata[4:0] = s.fmt;
        e1_tx_pkg::ADDR_TEMPLATE: n.rdata[3:0] = s.tsel;
        e1_tx_pkg::ADDR_TRIM: n.rdata[5:0] = s.trim;
        e1_tx_pkg::ADDR_ACCESS: n.rdata[6:0] = s.acc;
        e1_tx_pkg::ADDR_SAMPLE: n.rdata[6:0] = s.sdata;
        e1_tx_pkg::ADDR_LINE: n.rdata[7:0] = s.line;
        e1_tx_pkg::ADDR_STATUS: begin
          n.rdata[e1_tx_pkg::LOSS_BIT] = s.loss;
          n.rdata[e1_tx_pkg::OC_BIT] = s.oc_prev;
        end
        e1_tx_pkg::ADDR_FLAGS: n.rdata[7:0] = s.flags;
        e1_tx_pkg::ADDR_EDGE: n.rdata[7:0] = s.edgem;
        e1_tx_pkg::ADDR_MASK: n.rdata[7:0] = s.mask;
        default: n.rdata = 32'h0000_0000;
      endcase
    end else begin
      n.wreq = 1'b1;
    end
    if (avs_write_i && !s.wreq) begin
      case (avs_address_i & 6'h3c)
        e1_tx_pkg::ADDR_FORMAT: n.fmt = wd[4:0];
        e1_tx_pkg::ADDR_TEMPLATE: n.tsel = wd[3:0];
        e1_tx_pkg::ADDR_TRIM: n.trim = wd[5:0];
        e1_tx_pkg::ADDR_ACCESS: n.acc = wd[6:0];
        e1_tx_pkg::ADDR_SAMPLE: n.sdata = wd[6:0];
        e1_tx_pkg::ADDR_LINE: n.line = wd & 8'h50;
        e1_tx_pkg::ADDR_FLAGS: n.flags = s.flags & ~wd; // write 1 clears
        e1_tx_pkg::ADDR_EDGE: n.edgem = wd & e1_tx_pkg::EDGE_BITS;
        e1_tx_pkg::ADDR_MASK: n.mask = wd & e1_tx_pkg::FLAG_BITS;
        default: n.wreq = 1'b1;
      endcase
    end
    // sticky flags, a new event beats a same-cycle clear
    n.flags[e1_tx_pkg::LOSS_BIT] = n.flags[e1_tx_pkg::LOSS_BIT] | loss_ev;
    n.flags[e1_tx_pkg::OC_BIT] = n.flags[e1_tx_pkg::OC_BIT] | oc_ev;
    n.flags[e1_tx_pkg::OVF_BIT] = n.flags[e1_tx_pkg::OVF_BIT] |
                                  (sum > 9'sh03f) | (sum < -9'sh03f);
    n.irq_n = ~|(s.flags & ~s.mask);
    if (!nrst_i) begin
      n = '0;
      n.wreq = 1'b1;
      n.oe_n = 1'b1;
      n.irq_n = 1'b1;
      n.tsel = e1_tx_pkg::TSEL_RESET;
      n.trim = e1_tx_pkg::TRIM_RESET;
      n.mask = e1_tx_pkg::MASK_RESET;
      n.line[e1_tx_pkg::OE_BIT] = 1'b1;
      // user table starts as a copy of preset shape one
      for (int i = 0; i < e1_tx_pkg::PHASE_COUNT; i++) begin
        n.ram[i] = preset_sample(3'h1, 5'(i));
      end
    end
  end

  // single state register
  always_ff @(posedge ref_clk_i) begin
    s <= n;
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.wreq;
  assign line_out_positive_o = s.lp;
  assign line_out_negative_o = s.ln;
  assign line_oe_n_o = s.oe_n;
  assign current_limit_o = s.ilim;
  assign shaper_level_o = s.level;
  assign irq_n_o = s.irq_n;
endmodule
`default_nettype wire

/* File: rtl/e1_tx_pkg.sv */
// constants shared by both ends of the e1 transmit path
package e1_tx_pkg;
  // clock figures
  localparam int REF_CLK_KHZ = 100_000;
  localparam int E1_RATE_KHZ = 2_048;
  localparam int E1_TICK_CYCLES = REF_CLK_KHZ / E1_RATE_KHZ;
  localparam int PHASE_CYCLES = E1_TICK_CYCLES / 16;
  localparam int FRAMER_HALF_CYCLES = E1_TICK_CYCLES / 2;
  localparam int RZ_MIN_CYCLES = E1_TICK_CYCLES / 2;
  localparam int RZ_LATE_CYCLES = E1_TICK_CYCLES + E1_TICK_CYCLES / 4;
  localparam int LOSS_LIMIT = 64;
  localparam int PHASE_COUNT = 20;
  localparam int PHASE_LAST = PHASE_COUNT - 1;
  localparam int TAIL_PHASES = 4;
  localparam int TAIL_OFFSET = 16;
  // register byte addresses
  localparam logic [5:0] ADDR_FORMAT = 6'h00;
  localparam logic [5:0] ADDR_TEMPLATE = 6'h04;
  localparam logic [5:0] ADDR_TRIM = 6'h08;
  localparam logic [5:0] ADDR_ACCESS = 6'h0c;
  localparam logic [5:0] ADDR_SAMPLE = 6'h10;
  localparam logic [5:0] ADDR_LINE = 6'h14;
  localparam logic [5:0] ADDR_STATUS = 6'h18;
  localparam logic [5:0] ADDR_FLAGS = 6'h1c;
  localparam logic [5:0] ADDR_EDGE = 6'h20;
  localparam logic [5:0] ADDR_MASK = 6'h24;
  // field positions
  localparam int CODE_BIT = 2;
  localparam int POL_BIT = 3;
  localparam int CLKEDGE_BIT = 4;
  localparam int TSEL_USER_BIT = 3;
  localparam int DIR_BIT = 5;
  localparam int DONE_BIT = 6;
  localparam int FLOAT_BIT = 4;
  localparam int OE_BIT = 6;
  localparam int LOSS_BIT = 3;
  localparam int OC_BIT = 4;
  localparam int OVF_BIT = 7;
  localparam logic [7:0] FLAG_BITS = 8'h98;
  localparam logic [7:0] EDGE_BITS = 8'h18;
  // values after reset, nominal trim and preset rom levels
  localparam logic [5:0] TRIM_RESET = 6'h21;
  localparam logic [5:0] TRIM_NOMINAL = 6'h21;
  localparam logic [7:0] MASK_RESET = 8'h98;
  localparam logic [3:0] TSEL_RESET = 4'h1;
  localparam logic [5:0] PRESET_PEAK = 6'h3c;
  localparam logic [6:0] PRESET_UNDER = 7'h44;
  // input formats
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL_NRZ = 2'h1;
  localparam logic [1:0] MODE_DUAL_RZ = 2'h2;
  // encoder symbol kinds
  localparam logic [1:0] KIND_ZERO = 2'h0;
  localparam logic [1:0] KIND_MARK = 2'h1;
  localparam logic [1:0] KIND_BAL = 2'h2;
  localparam logic [1:0] KIND_VIOL = 2'h3;
endpackage

/* File: rtl/e1_tx_link_if.sv */
// link wires between the framer and the transmit path
`timescale 1ns/1ps
`default_nettype none
interface e1_tx_link_if;
  logic tx_single_rail_data;
  logic tx_positive_rail;
  logic tx_negative_rail;
  logic tx_system_clock;
  modport device (
    input tx_single_rail_data, tx_positive_rail, tx_negative_rail,
    input tx_system_clock
  );
  modport framer (
    output tx_single_rail_data, tx_positive_rail, tx_negative_rail,
    output tx_system_clock
  );
endinterface
`default_nettype wire

/* File: rtl/e1_tx_framer.sv */
// system-side framer end: drives data and makes the transmit clock
`timescale 1ns/1ps
`default_nettype none
module e1_tx_framer #(
  parameter int HALF_CYCLES = e1_tx_pkg::FRAMER_HALF_CYCLES
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic nrst_i, // sync reset, active low
  e1_tx_link_if.framer link, // link to the device
  input wire logic [1:0] mode_i, // input format to drive
  input wire logic edge_falling_i, // device samples on falling edge
  input wire logic clock_run_i, // 0 stops the clock
  input wire logic bit_i, // next single rail bit
  input wire logic pos_i, // next positive rail symbol
  input wire logic neg_i, // next negative rail symbol
  output logic bit_take_o // pulse: inputs were launched
);
  typedef struct packed {
    logic [7:0] div;
    logic phase;
    logic clk;
    logic sd;
    logic p;
    logic n;
    logic take;
  } framer_state_type;

  framer_state_type s, next_s;
  logic half;
  logic launch;

  // divider, launch on the edge the device does not sample
  always_comb begin
    next_s = s;
    next_s.take = 1'b0;
    half = (s.div == 8'(HALF_CYCLES - 1));
    launch = 1'b0;
    next_s.div = half ? 8'h00 : s.div + 8'h01;
    if (half) begin
      next_s.phase = ~s.phase;
      if (mode_i == e1_tx_pkg::MODE_DUAL_RZ) begin
        // no clock; rails return to zero mid bit
        next_s.clk = 1'b0;
        launch = ~s.phase;
        if (s.phase) begin
          next_s.p = 1'b0;
          next_s.n = 1'b0;
        end
      end else begin
        next_s.clk = ~s.phase & clock_run_i;
        launch = (~s.phase) == edge_falling_i;
      end
    end
    if (launch) begin
      next_s.take = 1'b1;
      next_s.sd = bit_i;
      next_s.p = pos_i;
      next_s.n = neg_i;
    end
    if (!nrst_i) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

  assign link.tx_single_rail_data = s.sd;
  assign link.tx_positive_rail = s.p;
  assign link.tx_negative_rail = s.n;
  assign link.tx_system_clock = s.clk;
  assign bit_take_o = s.take;
endmodule
`default_nettype wire

/* File: tb/e1_transmit_path_asserts.sv */
// concurrent checks on the link and the device side ports
`timescale 1ns/1ps
`default_nettype none
module e1_transmit_path_asserts (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic tx_single_rail_data, // link data
  input wire logic tx_system_clock, // link clock
  input wire logic edge_falling_i, // device samples falling edge
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_readdata_o, // read data
  input wire logic avs_waitrequest_o, // stall
  input wire logic global_oe_i, // global enable pin
  input wire logic tx_overcurrent_i, // over-current pin
  input wire logic line_out_positive_o, // positive level
  input wire logic line_out_negative_o, // negative level
  input wire logic line_oe_n_o, // low while driving
  input wire logic current_limit_o // limiting
);
  // one clock domain, so one default for all
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  AST_ANSWER: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one cycle");
  AST_ONE_CYCLE: assert property (!avs_waitrequest_o |=>
    avs_waitrequest_o) else $error("answer held too long");
  AST_UPPER_ZERO: assert property (!avs_waitrequest_o |->
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  AST_GLOBAL_FLOAT: assert property (!global_oe_i [*4] |=>
    line_oe_n_o) else $error("driver not floated by the pin");
  AST_OC_ACTION: assert property (tx_overcurrent_i [*4] |=>
    current_limit_o || line_oe_n_o)
    else $error("over-current neither limited nor floated");
  AST_OC_RELEASE: assert property (!tx_overcurrent_i [*4] |=>
    !current_limit_o) else $error("limit without over-current");
  AST_LINE_SIGN: assert property (!(line_out_positive_o &&
    line_out_negative_o)) else $error("both line signs at once");
  // data must settle away from the clock edge the device samples
  AST_DATA_OFF_EDGE: assert property (($past(edge_falling_i) ?
    $fell(tx_system_clock) : $rose(tx_system_clock)) |->
    $stable(tx_single_rail_data)) else $error("data moved with clock");
  AST_CLK_HALF: assert property ($changed(tx_system_clock) |=>
    $stable(tx_system_clock) [*8]) else $error("link clock too fast");
endmodule
`default_nettype wire

/* File: tb/e1_transmit_path_tb.sv */
// self-checking bench: framer and transmit path back to back
`timescale 1ns/1ps
`default_nettype none
module e1_transmit_path_tb;
  localparam int BIT = 2 * e1_tx_pkg::FRAMER_HALF_CYCLES;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic efall = 1'b0, crun = 1'b1, bit_d = 1'b0, pos_d = 1'b0, neg_d = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0, wr = 1'b0, goe = 1'b1, oc = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq, lp, ln, oen, clim, irqn, was_zero, last_neg;
  logic [6:0] lvl;
  int n_fail = 0, num_checks = 0, cycles = 0;
  int n_pos, n_neg, n_same, peak;

  always #5 clk = ~clk;

  e1_tx_link_if e1_tx_link_if_inst ();
  e1_tx_framer e1_tx_framer_inst (.ref_clk_i(clk), .nrst_i(nrst),
    .link(e1_tx_link_if_inst.framer), .mode_i(mode), .edge_falling_i(efall),
    .clock_run_i(crun), .bit_i(bit_d), .pos_i(pos_d), .neg_i(neg_d),
    .bit_take_o());
  e1_tx_device e1_tx_device_inst (.ref_clk_i(clk), .nrst_i(nrst),
    .link(e1_tx_link_if_inst.device), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .global_oe_i(goe),
    .tx_overcurrent_i(oc), .line_out_positive_o(lp),
    .line_out_negative_o(ln), .line_oe_n_o(oen), .current_limit_o(clim),
    .shaper_level_o(lvl), .irq_n_o(irqn));
  e1_transmit_path_asserts e1_transmit_path_asserts_inst (.ref_clk_i(clk),
    .nrst_i(nrst),
    .tx_single_rail_data(e1_tx_link_if_inst.tx_single_rail_data),
    .tx_system_clock(e1_tx_link_if_inst.tx_system_clock),
    .edge_falling_i(efall),
    .avs_read_i(rd), .avs_write_i(wr), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .global_oe_i(goe), .tx_overcurrent_i(oc),
    .line_out_positive_o(lp), .line_out_negative_o(ln),
    .line_oe_n_o(oen), .current_limit_o(clim));

  // pulse starts: first nonzero level after a zero one
  always @(posedge clk) begin
    if (lvl[5:0] != 6'h00 && was_zero) begin
      if (n_pos + n_neg > 0 && lvl[6] == last_neg) n_same++;
      if (lvl[6]) n_neg++;
      else n_pos++;
      last_neg = lvl[6];
    end
    if (int'(lvl[5:0]) > peak) peak = int'(lvl[5:0]);
    was_zero = (lvl[5:0] == 6'h00);
  end

  // hang guard, well above the expected run of some 15k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      $display("BAD run length expected end seen hang");
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // one bus access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk("bus answer", 32'(n), 32'h1);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string s, input logic [5:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(s, q, e);
  endtask

  task automatic wphase(input logic [4:0] i, input logic [6:0] v);
    wrr(6'h10, {1'b0, v});
    wrr(6'h0c, {3'b010, i}); // write with done set
  endtask

  // ends on a falling edge so outputs and counters have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic watch(input int n);
    @(negedge clk);
    n_pos = 0;
    n_neg = 0;
    n_same = 0;
    peak = 0;
    settle(n);
  endtask

  // format change, then pipeline flush before counting pulses
  task automatic stream(input logic [7:0] f, input logic b,
                        input logic p, input logic n);
    wrr(6'h00, f);
    mode <= f[1:0];
    efall <= f[e1_tx_pkg::CLKEDGE_BIT];
    bit_d <= b;
    pos_d <= p;
    neg_d <= n;
    repeat (8 * BIT) @(posedge clk);
    watch(16 * BIT);
  endtask

  task automatic t_regs();
    logic [5:0] ra [11] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14,
                           6'h18, 6'h1c, 6'h20, 6'h24, 6'h28};
    logic [7:0] re [11] = '{8'h00, 8'h01, 8'h21, 8'h00, 8'h00, 8'h40,
                           8'h00, 8'h00, 8'h00, 8'h98, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rdc("reset value", ra[i], {24'h00_0000, re[i]});
    end
    wrr(6'h28, 8'hff);
    rdc("unmapped", 6'h28, 32'h0);
    wrr(6'h18, 8'hff);
    rdc("status read only", 6'h18, 32'h0);
    wrr(6'h08, 8'h3f);
    rdc("trim", 6'h08, 32'h3f);
    wrr(6'h08, 8'h21);
    $display("registers done");
  endtask

  task automatic t_wave();
    logic [31:0] q;
    wrr(6'h0c, 8'h60);
    bus(1'b0, 6'h0c, 8'h00, q);
    chk("done clears", {31'h0, q[6]}, 32'h0);
    rdc("preset peak", 6'h10,
        32'(e1_tx_pkg::PRESET_PEAK - 6'h01));
    wrr(6'h0c, 8'h68);
    rdc("preset under", 6'h10, 32'(e1_tx_pkg::PRESET_UNDER));
    for (int i = 0; i < 20; i++) begin
      wphase(i[4:0], (i == 0) ? 7'h3f : (i == 19) ? 7'h7f : 7'h00);
    end
    wrr(6'h10, 8'h00);
    wrr(6'h0c, 8'h73);
    rdc("user phase", 6'h10, 32'h7f);
    wrr(6'h0c, 8'h74);
    rdc("no phase 20", 6'h10, 32'h7f);
    $display("waveform access done");
  endtask

  task automatic t_fmt();
    stream(8'h00, 1'b1, 1'b0, 1'b0);
    chk("ami alternates", 32'(n_same), 32'h0);
    chk("ami marks", {31'h0, n_neg > 4}, 32'h1);
    stream(8'h00, 1'b0, 1'b0, 1'b0);
    chk("ami zeros", 32'(n_pos + n_neg), 32'h0);
    stream(8'h04, 1'b0, 1'b0, 1'b0);
    chk("hdb3 violations", {31'h0, n_same > 0}, 32'h1);
    stream(8'h18, 1'b0, 1'b0, 1'b0);
    chk("inverted", {31'h0, n_pos > 4 && n_same == 0}, 32'h1);
    stream(8'h01, 1'b0, 1'b1, 1'b0);
    chk("dual bypass", {31'h0, n_pos > 4 && n_neg == 0},
        32'h1);
    stream(8'h02, 1'b0, 1'b0, 1'b1);
    chk("rz rails", {31'h0, n_neg > 4 && n_pos == 0},
        32'h1);
    chk("rz no clock",
        {31'h0, e1_tx_link_if_inst.tx_system_clock}, 32'h0);
    $display("formats done");
  endtask

  task automatic t_shape();
    wrr(6'h04, 8'h08);
    stream(8'h01, 1'b0, 1'b1, 1'b0);
    chk("user tail", {31'h0, n_neg > 4}, 32'h1);
    chk("user peak", 32'(peak), 32'((63 * 33 * 31) >> 10));
    wrr(6'h04, 8'h01);
    for (int t = 32; t < 35; t++) begin
      wrr(6'h08, 8'(t));
      settle(BIT);
      watch(8 * BIT);
      chk("trim peak", 32'(peak), 32'((59 * t * 31) >> 10));
    end
    wrr(6'h08, 8'h21);
    wrr(6'h04, 8'h08);
    wphase(5'h10, 7'h3f);
    settle(4 * BIT);
    rdc("overflow", 6'h1c, 32'h80);
    chk("masked", {31'h0, irqn}, 32'h1);
    wrr(6'h24, 8'h18);
    settle(3);
    chk("overflow irq", {31'h0, irqn}, 32'h0);
    wrr(6'h24, 8'h98);
    wrr(6'h04, 8'h01);
    wrr(6'h1c, 8'h80);
    $display("shaper done");
  endtask

  task automatic t_oe();
    settle(1);
    chk("driving", {31'h0, oen}, 32'h0);
    @(posedge clk);
    goe <= 1'b0;
    watch(4 * BIT);
    chk("global float", {31'h0, oen}, 32'h1);
    chk("logic runs", {31'h0, n_pos > 0}, 32'h1);
    @(posedge clk);
    goe <= 1'b1;
    wrr(6'h14, 8'h00);
    settle(3);
    chk("channel float", {31'h0, oen}, 32'h1);
    wrr(6'h14, 8'h40);
    $display("output enable done");
  endtask

  task automatic t_oc();
    @(posedge clk);
    oc <= 1'b1;
    settle(6);
    chk("limit", {31'h0, clim}, 32'h1);
    rdc("oc status", 6'h18, 32'h10);
    rdc("oc flag", 6'h1c, 32'h10);
    wrr(6'h14, 8'h50);
    settle(3);
    chk("oc float", {31'h0, oen}, 32'h1);
    wrr(6'h1c, 8'h10);
    oc <= 1'b0;
    settle(6);
    chk("limit off", {31'h0, clim}, 32'h0);
    rdc("fall ignored", 6'h1c, 32'h0);
    wrr(6'h14, 8'h40);
    $display("over-current done");
  endtask

  // stop the framer clock and watch the 64-tick limit
  task automatic t_loss();
    stream(8'h00, 1'b1, 1'b0, 1'b0);
    crun <= 1'b0;
    settle(60 * BIT);
    rdc("not yet lost", 6'h18, 32'h0);
    settle(8 * BIT);
    chk("loss float", {31'h0, oen}, 32'h1);
    rdc("loss status", 6'h18, 32'h08);
    rdc("loss flag", 6'h1c, 32'h08);
    wrr(6'h24, 8'h90);
    settle(3);
    chk("loss irq", {31'h0, irqn}, 32'h0);
    wrr(6'h1c, 8'h08);
    rdc("rise only", 6'h1c, 32'h0);
    wrr(6'h20, 8'h08);
    crun <= 1'b1;
    settle(2 * BIT);
    rdc("loss gone", 6'h18, 32'h0);
    rdc("any change", 6'h1c, 32'h08);
    $display("clock loss done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_wave();
    t_fmt();
    t_shape();
    t_oe();
    t_oc();
    t_loss();
    complete_run();
  end
endmodule
`default_nettype wire
